// ### bench/gpef_monitor.sv
// Port-level checks of the two-port GPIO block.
// Assumes the register map and standby gating of the block's package.
`timescale 1ns/1ps
`default_nettype none

module gpef_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic standby_entry_i,
  input wire logic [3:0] ext_irq_enable_i,
  input wire logic [3:0] ext_irq_level_o,
  input wire logic external_reset_enable_o,
  input wire logic [3:0] pe_pin_i,
  input wire logic [3:0] pe_pin_o,
  input wire logic [3:0] pe_pin_oe_o,
  input wire logic [3:0] pe_pullup_o,
  input wire logic [2:0] pf_pin_oe_o
);
  // ======
  // Helper state
  // ======
  logic take;
  logic wr_en;
  logic spl_reg;
  logic spl_next;
  logic [1:0] up_reg;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = take && wb_we_i && wb_sel_i[0];
  // The standby pin-state bit is internal, so it is followed from the bus writes.
  assign spl_next = (wr_en && wb_adr_i[7:2] == gpef_pkg::GPEF_OFS_STANDBY[7:2]) ? wb_dat_i[0] : spl_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spl_reg <= 1'b0;
      up_reg <= 2'd0;
    end else begin
      spl_reg <= spl_next;
      up_reg <= (up_reg == 2'd3) ? up_reg : up_reg + 2'd1;
    end
  end

  // ======
  // Assertions
  // ======
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_reset_inputs: assert property (disable iff (1'b0) rst_i |=> pe_pin_oe_o == 4'h0 && pf_pin_oe_o == 3'h0)
    else $error("pin driven after reset");
  a_dir_sets_oe: assert property (wr_en && wb_adr_i[7:2] == gpef_pkg::GPEF_OFS_PE_DIR[7:2] ##1 !standby_entry_i
    |-> pe_pin_oe_o == $past(wb_dat_i[3:0])) else $error("enable does not follow direction write");
  a_latch_to_pin: assert property (wr_en && wb_adr_i[7:2] == gpef_pkg::GPEF_OFS_PE_DATA[7:2]
    |=> pe_pin_o == $past(wb_dat_i[3:0])) else $error("drive value does not follow data write");
  a_pullup_low_off: assert property ((pe_pullup_o & pe_pin_oe_o & ~pe_pin_o) == 4'h0)
    else $error("pull-up on a pin driven low");
  a_reset_pin_off: assert property (external_reset_enable_o |-> !pf_pin_oe_o[2])
    else $error("shared reset pin driven");
  a_standby_float: assert property (spl_reg && standby_entry_i |-> pe_pin_oe_o == 4'h0 && pf_pin_oe_o == 3'h0)
    else $error("pin driven in standby");
  a_standby_hold: assert property (!spl_reg && !wb_ack_o && $rose(standby_entry_i)
    |-> $stable(pe_pin_oe_o) && $stable(pf_pin_oe_o)) else $error("pins changed on standby entry");
  a_irq_path: assert property ((up_reg == 2'd3 && $stable(pe_pin_i)) [*3]
    |-> ((ext_irq_level_o ^ (pe_pin_i & ~({4{spl_reg && standby_entry_i}} & ~ext_irq_enable_i))) == 4'h0))
    else $error("interrupt level does not follow the pin");
endmodule

`default_nettype wire

// ### bench/gpef_pin_model.sv
// Pads of both ports: the device's drive, else the bench's drive, else the port E pull-up.
// Assumes the bench drives only pins that it has enabled here.
`timescale 1ns/1ps
`default_nettype none

module gpef_pin_model (
  input wire logic clk_i,
  input wire logic [3:0] e_out_i,
  input wire logic [3:0] e_oe_i,
  input wire logic [3:0] e_pu_i,
  input wire logic [2:0] f_out_i,
  input wire logic [2:0] f_oe_i,
  input wire logic [3:0] ext_e_i,
  input wire logic [3:0] ext_e_en_i,
  input wire logic [2:0] ext_f_i,
  input wire logic [2:0] ext_f_en_i,
  output logic [3:0] e_pad_o,
  output logic [2:0] f_pad_o
);
  // A floating pin wanders every cycle so that its reading never matches by luck.
  logic [3:0] wander = 4'h5;
  always @(posedge clk_i) wander <= ~wander;
  // Shared peripheral outputs stay off, so only the port and the bench drive a pad.
  assign e_pad_o = (e_oe_i & e_out_i) | (~e_oe_i & ((ext_e_en_i & ext_e_i) | (~ext_e_en_i & (e_pu_i | wander))));
  assign f_pad_o = (f_oe_i & f_out_i) | (~f_oe_i & ((ext_f_en_i & ext_f_i) | (~ext_f_en_i & wander[2:0])));
endmodule

`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench of the two-port GPIO block over its Wishbone register bus.
// Assumes the pad model on the pins and the port checker bound to the top module.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic standby_entry_i = 1'b0;
  logic [3:0] ext_irq_enable_i = 4'h0;
  logic [3:0] ext_e = 4'h0;
  logic [2:0] ext_f = 3'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, external_reset_enable_o;
  logic [3:0] ext_irq_level_o, pe_pin_i, pe_pin_o, pe_pin_oe_o, pe_pullup_o, dir, lat, pu;
  logic [2:0] pf_pin_i, pf_pin_o, pf_pin_oe_o, fdir, flat;
  logic [31:0] expq[$];
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int i;

  always #2.5 clk_i = ~clk_i;
  gpef_top gpef_top_inst (.*);
  gpef_pin_model gpef_pin_model_inst (.clk_i(clk_i), .e_out_i(pe_pin_o), .e_oe_i(pe_pin_oe_o),
    .e_pu_i(pe_pullup_o), .f_out_i(pf_pin_o), .f_oe_i(pf_pin_oe_o), .ext_e_i(ext_e), .ext_e_en_i(4'hf),
    .ext_f_i(ext_f), .ext_f_en_i(3'h7), .e_pad_o(pe_pin_i), .f_pad_o(pf_pin_i));

  // ======
  // Tasks
  // ======
  task automatic fail(input string msg);
    $display("Error %0t: %s", $time, msg);
    err_count++;
  endtask
  task automatic cmp_pin(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("pins %h, expected %h", got, exp));
  endtask
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) fail($sformatf("read %h, expected %h", got, exp));
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s = 4'hf);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_sel_i <= s;
    wb_dat_i <= {24'($urandom()), d};
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) fail("no acknowledge");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    bus(a, 1'b0, 8'h00);
  endtask
  // Lets the synchronisers catch up, then samples between edges.
  task automatic settle();
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic summarize();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ======
  // Result watcher and timeout
  // ======
  always @(posedge clk_i) begin
    cycles++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (expq.size() == 0) fail("read without expectation");
      else cmp_rd(wb_dat_o, expq.pop_front());
    end
    if (cycles == 20000) begin
      fail("timeout");
      summarize();
    end
  end

  // ======
  // Tests
  // ======
  initial begin
    i = $urandom(32'h0000_e493);
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp_pin(pe_pin_oe_o, 4'h0);
    cmp_pin({1'b0, pf_pin_oe_o}, 4'h0);
    rd(gpef_pkg::GPEF_OFS_PE_DIR, 32'h0000_0000);
    rd(gpef_pkg::GPEF_OFS_PF_DIR, 32'h0000_0000);
    rd(gpef_pkg::GPEF_OFS_SYSCFG, {31'h0, gpef_pkg::GPEF_RST_EXTERNAL_RESET_ENABLE});
    $display("Test reset values done");
    for (i = 0; i < 8; i++) begin
      lat = 4'($urandom());
      dir = 4'($urandom());
      pu = 4'($urandom());
      ext_e <= 4'($urandom());
      bus(gpef_pkg::GPEF_OFS_PE_DATA, 1'b1, {4'($urandom()), lat});
      bus(gpef_pkg::GPEF_OFS_PE_DIR, 1'b1, {4'hf, dir});
      bus(gpef_pkg::GPEF_OFS_PE_PULLUP, 1'b1, {4'h0, pu});
      settle();
      cmp_pin(pe_pin_oe_o, dir);
      cmp_pin(pe_pin_o, lat);
      cmp_pin(pe_pullup_o, pu & ~(dir & ~lat));
      cmp_pin(ext_irq_level_o, (dir & lat) | (~dir & ext_e));
      @(posedge clk_i);
      rd(gpef_pkg::GPEF_OFS_PE_DATA, {28'h0, (dir & lat) | (~dir & ext_e)});
      rd(gpef_pkg::GPEF_OFS_PE_RMW, {28'h0, lat});
      rd(gpef_pkg::GPEF_OFS_PE_DIR, {28'h0, dir});
      rd(gpef_pkg::GPEF_OFS_PE_PULLUP, {28'h0, pu});
    end
    $display("Test port E done");
    bus(gpef_pkg::GPEF_OFS_SYSCFG, 1'b1, 8'h00);
    for (i = 0; i < 8; i++) begin
      flat = 3'($urandom());
      fdir = 3'($urandom());
      ext_f <= 3'($urandom());
      bus(gpef_pkg::GPEF_OFS_PF_DATA, 1'b1, {5'h1f, flat});
      bus(gpef_pkg::GPEF_OFS_PF_DIR, 1'b1, {5'h00, fdir});
      settle();
      cmp_pin({1'b0, pf_pin_oe_o}, {1'b0, fdir & ~(flat & 3'h4)});
      cmp_pin({1'b0, pf_pin_o & pf_pin_oe_o}, {1'b0, flat & fdir & 3'h3});
      @(posedge clk_i);
      rd(gpef_pkg::GPEF_OFS_PF_DATA, {29'h0, (fdir & flat) | (~fdir & ext_f)});
      rd(gpef_pkg::GPEF_OFS_PF_RMW, {29'h0, flat});
    end
    bus(gpef_pkg::GPEF_OFS_SYSCFG, 1'b1, 8'h01);
    bus(gpef_pkg::GPEF_OFS_PF_DIR, 1'b1, 8'h07);
    bus(gpef_pkg::GPEF_OFS_PF_DATA, 1'b1, 8'h00);
    settle();
    cmp_pin({external_reset_enable_o, pf_pin_oe_o}, 4'hb);
    @(posedge clk_i);
    $display("Test port F done");
    ext_irq_enable_i <= 4'($urandom());
    bus(gpef_pkg::GPEF_OFS_PE_DIR, 1'b1, 8'h03);
    bus(gpef_pkg::GPEF_OFS_PE_DATA, 1'b1, 8'h05);
    standby_entry_i <= 1'b1;
    settle();
    cmp_pin(pe_pin_oe_o, 4'h3);
    cmp_pin(ext_irq_level_o, 4'h1 | (4'hc & ext_e));
    @(posedge clk_i);
    bus(gpef_pkg::GPEF_OFS_STANDBY, 1'b1, 8'h01);
    settle();
    cmp_pin(pe_pin_oe_o | {1'b0, pf_pin_oe_o}, 4'h0);
    cmp_pin(ext_irq_level_o, ext_e & ext_irq_enable_i);
    @(posedge clk_i);
    rd(gpef_pkg::GPEF_OFS_STANDBY, 32'h0000_0001);
    // Status shows the raw synchronised levels, the floating flag and the reset enable.
    rd(gpef_pkg::GPEF_OFS_STATUS, {13'h0, ext_f, 4'h0, ext_e, 8'h03});
    standby_entry_i <= 1'b0;
    $display("Test standby done");
    bus(8'h3c, 1'b1, 8'hff);
    rd(8'h3c, 32'h0000_0000);
    // A write without the low byte lane enabled must leave the direction untouched.
    bus(gpef_pkg::GPEF_OFS_PE_DIR, 1'b1, 8'h0c, 4'he);
    rd(gpef_pkg::GPEF_OFS_PE_DIR, 32'h0000_0003);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmp_pin(pe_pin_oe_o, 4'h0);
    rd(gpef_pkg::GPEF_OFS_PE_DIR, 32'h0000_0000);
    $display("Test unmapped and reset done");
    repeat (3) @(posedge clk_i);
    summarize();
  end
endmodule

bind gpef_top gpef_monitor gpef_monitor_inst (.*);

`default_nettype wire

// ### logic/gpef_pad_ctrl.sv
// Pad control for one port: drive, enable, pull-up and input gating.
// Assumes all inputs come from flip-flops or synchronisers on the same clock.
`timescale 1ns/1ps
`default_nettype none

module gpef_pad_ctrl #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] OPEN_DRAIN = '0
) (
  gpef_pad_if.pad pad
);

  logic [W-1:0] blocked;

  // An open-drain pin never drives high; its latch value of 1 releases the pin instead.
  assign pad.pin_out = pad.latch & ~OPEN_DRAIN;

  // Standby high-impedance overrides direction; an unavailable pin never drives.
  assign pad.pin_oe = pad.dir & pad.avail & ~{W{pad.force_hiz}}
                      & ~(OPEN_DRAIN & pad.latch);

  // The pull-up is cut off while the pin drives low.
  assign pad.pullup_on = pad.pullup_en & ~(pad.pin_oe & ~pad.pin_out);

  // In standby the input is held low unless an enabled interrupt keeps it open.
  assign blocked = {W{pad.force_hiz}} & ~pad.keep_open;
  assign pad.in_gated = pad.level & ~blocked & pad.avail;

endmodule

`default_nettype wire

// ### logic/gpef_pad_if.sv
// Carries the control and sense signals between the register logic and one port's pad control.
// Assumes one instance per port, sized by W.
`timescale 1ns/1ps
`default_nettype none

interface gpef_pad_if #(
  parameter int unsigned W = 4
);
  logic [W-1:0] latch;
  logic [W-1:0] dir;
  logic [W-1:0] pullup_en;
  logic [W-1:0] avail;
  logic [W-1:0] keep_open;
  logic force_hiz;
  logic [W-1:0] level;
  logic [W-1:0] in_gated;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_oe;
  logic [W-1:0] pullup_on;

  modport ctrl (output latch, dir, pullup_en, avail, keep_open, force_hiz, level,
                input in_gated, pin_out, pin_oe, pullup_on);
  modport pad (input latch, dir, pullup_en, avail, keep_open, force_hiz, level,
               output in_gated, pin_out, pin_oe, pullup_on);
endinterface

`default_nettype wire

// ### logic/gpef_pkg.sv
// Holds the register map, field positions, reset values and state type of the two-port GPIO block.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
`default_nettype none

package gpef_pkg;

  // ==========================================================================
  // Port widths
  // ==========================================================================
  localparam int unsigned GPEF_PE_W = 4;
  localparam int unsigned GPEF_PF_W = 3;
  localparam int unsigned GPEF_PF_RST_PIN = 2;

  // ==========================================================================
  // Register byte offsets
  // ==========================================================================
  localparam logic [7:0] GPEF_OFS_PE_DATA = 8'h00;
  localparam logic [7:0] GPEF_OFS_PE_DIR = 8'h04;
  localparam logic [7:0] GPEF_OFS_PE_PULLUP = 8'h08;
  localparam logic [7:0] GPEF_OFS_PF_DATA = 8'h0C;
  localparam logic [7:0] GPEF_OFS_PF_DIR = 8'h10;
  localparam logic [7:0] GPEF_OFS_STANDBY = 8'h14;
  localparam logic [7:0] GPEF_OFS_SYSCFG = 8'h18;
  localparam logic [7:0] GPEF_OFS_STATUS = 8'h1C;
  localparam logic [7:0] GPEF_OFS_PE_RMW = 8'h20;
  localparam logic [7:0] GPEF_OFS_PF_RMW = 8'h24;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned GPEF_SPL_BIT = 0;
  localparam int unsigned GPEF_EXTERNAL_RESET_ENABLE_BIT = 0;
  localparam int unsigned GPEF_STAT_HIZ_BIT = 0;
  localparam int unsigned GPEF_STAT_EXTERNAL_RESET_ENABLE_BIT = 1;
  localparam int unsigned GPEF_STAT_PE_LSB = 8;
  localparam int unsigned GPEF_STAT_PF_LSB = 16;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [GPEF_PE_W-1:0] GPEF_RST_PE_LATCH = 4'h0;
  localparam logic [GPEF_PE_W-1:0] GPEF_RST_PE_DIR = 4'h0;
  localparam logic [GPEF_PE_W-1:0] GPEF_RST_PE_PULLUP = 4'h0;
  localparam logic [GPEF_PF_W-1:0] GPEF_RST_PF_LATCH = 3'h0;
  localparam logic [GPEF_PF_W-1:0] GPEF_RST_PF_DIR = 3'h0;
  localparam logic GPEF_RST_SPL = 1'b0;
  localparam logic GPEF_RST_EXTERNAL_RESET_ENABLE = 1'b1;

  // ==========================================================================
  // Register state of the top module
  // ==========================================================================
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [GPEF_PE_W-1:0] pe_latch;
    logic [GPEF_PE_W-1:0] pe_dir;
    logic [GPEF_PE_W-1:0] pe_pullup;
    logic [GPEF_PF_W-1:0] pf_latch;
    logic [GPEF_PF_W-1:0] pf_dir;
    logic standby_pin_state_bit;
    logic external_reset_enable;
  } gpef_state_t;

endpackage

`default_nettype wire

// ### logic/gpef_sync.sv
// Two-stage synchroniser for pin levels arriving from outside the clock domain.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module gpef_sync #(
  parameter int unsigned W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } gpef_sync_state_t;

  gpef_sync_state_t state_reg;
  gpef_sync_state_t state_next;

  always_comb begin
    state_next.meta = async_i;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_o = state_reg.stable;

endmodule

`default_nettype wire

// ### logic/gpef_top.sv
// Top of the two-port GPIO block: Wishbone register file, pin synchronisers and pad control.
// Assumes a 200 MHz clock, a synchronous active-high reset and a standby request from the
// power controller on the same clock.
//
// Overview of operation
// - A direction bit of 1 makes its own pin an output and 0 makes it an input.
// - An output pin drives the value held in its data latch bit.
// - A data write always updates the latch, which reaches an input pin only once it becomes an output.
// - An ordinary data read returns the latch bit for an output pin.
// - An ordinary data read returns the pin level for an input pin, while a read-modify-write read returns the latch.
// - A pin used as a peripheral input still reads as its level, and as its latch in read-modify-write reads.
// - Reset clears every direction bit so both ports start as inputs.
// - With the standby pin-state bit set, stop or watch mode floats every pin and forces its input low.
// - A port E pin with its external interrupt enabled keeps its input path open in standby.
// - With the standby pin-state bit clear, stop or watch mode leaves the pins as they are.
// - Every port E pin level goes to the external interrupt circuit, except while standby forces its input low.
// - A pull-up bit of 1 connects the port E pin's internal pull-up.
// - The pull-up is disconnected whenever the pin drives low.
// - An open-drain output pin with a latch value of 1 floats instead of driving high.
// - With external reset enabled, the shared reset pin of port F has no port function.
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module gpef_top #(
  parameter logic [2:0] PF_OPEN_DRAIN = 3'h4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic standby_entry_i,
  input wire logic [3:0] ext_irq_enable_i,
  output logic [3:0] ext_irq_level_o,
  output logic external_reset_enable_o,
  input wire logic [3:0] pe_pin_i,
  output logic [3:0] pe_pin_o,
  output logic [3:0] pe_pin_oe_o,
  output logic [3:0] pe_pullup_o,
  input wire logic [2:0] pf_pin_i,
  output logic [2:0] pf_pin_o,
  output logic [2:0] pf_pin_oe_o
);

  localparam int unsigned PE_W = gpef_pkg::GPEF_PE_W;
  localparam int unsigned PF_W = gpef_pkg::GPEF_PF_W;

  // ==========================================================================
  // Decode helpers
  // ==========================================================================

  // Compares word addresses so that low address bits do not split a register.
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    reg_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Ordinary data read: latch for outputs, gated pin level for inputs.
  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] level);
    port_read = (dir & latch) | (~dir & level);
  endfunction

  // ==========================================================================
  // State and wiring
  // ==========================================================================
  gpef_pkg::gpef_state_t state_reg;
  gpef_pkg::gpef_state_t state_next;

  logic [PE_W-1:0] pe_level;
  logic [PF_W-1:0] pf_level;
  logic [PF_W-1:0] pf_avail;
  logic force_hiz;
  logic bus_req;
  logic bus_wr;
  logic [7:0] wr_byte;
  logic [7:0] pe_rd_ordinary;
  logic [7:0] pf_rd_ordinary;
  logic [31:0] status_word;
  logic [31:0] rd_word;

  gpef_pad_if #(.W(PE_W)) pe_pad ();
  gpef_pad_if #(.W(PF_W)) pf_pad ();

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  gpef_sync #(
    .W(PE_W)
  ) u_pe_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pe_pin_i),
    .sync_o(pe_level)
  );

  gpef_sync #(
    .W(PF_W)
  ) u_pf_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(pf_pin_i),
    .sync_o(pf_level)
  );

  // ==========================================================================
  // Standby and pin availability
  // ==========================================================================

  // Floating only happens while software has chosen it and stop or watch mode is requested, in either order.
  assign force_hiz = state_reg.standby_pin_state_bit & standby_entry_i;

  // The shared reset pin leaves port use while external reset is enabled.
  always_comb begin
    pf_avail = '1;
    pf_avail[gpef_pkg::GPEF_PF_RST_PIN] = ~state_reg.external_reset_enable;
  end

  // ==========================================================================
  // Pad control for port E
  // ==========================================================================
  assign pe_pad.latch = state_reg.pe_latch;
  assign pe_pad.dir = state_reg.pe_dir;
  assign pe_pad.pullup_en = state_reg.pe_pullup;
  assign pe_pad.avail = '1;
  assign pe_pad.keep_open = ext_irq_enable_i;
  assign pe_pad.force_hiz = force_hiz;
  assign pe_pad.level = pe_level;

  gpef_pad_ctrl #(
    .W(PE_W),
    .OPEN_DRAIN('0)
  ) u_pe_pad (
    .pad(pe_pad)
  );

  // ==========================================================================
  // Pad control for port F
  // ==========================================================================
  assign pf_pad.latch = state_reg.pf_latch;
  assign pf_pad.dir = state_reg.pf_dir;
  assign pf_pad.pullup_en = '0;
  assign pf_pad.avail = pf_avail;
  assign pf_pad.keep_open = '0;
  assign pf_pad.force_hiz = force_hiz;
  assign pf_pad.level = pf_level;

  gpef_pad_ctrl #(
    .W(PF_W),
    .OPEN_DRAIN(PF_OPEN_DRAIN)
  ) u_pf_pad (
    .pad(pf_pad)
  );

  // ==========================================================================
  // Pin outputs
  // ==========================================================================
  assign pe_pin_o = pe_pad.pin_out;
  assign pe_pin_oe_o = pe_pad.pin_oe;
  assign pe_pullup_o = pe_pad.pullup_on;
  assign pf_pin_o = pf_pad.pin_out;
  assign pf_pin_oe_o = pf_pad.pin_oe;

  // The interrupt circuit sees every port E level, gated only by standby blocking.
  assign ext_irq_level_o = pe_pad.in_gated;
  assign external_reset_enable_o = state_reg.external_reset_enable;

  // ==========================================================================
  // Read data assembly
  // ==========================================================================
  assign pe_rd_ordinary = port_read({4'h0, state_reg.pe_dir}, {4'h0, state_reg.pe_latch},
                                    {4'h0, pe_pad.in_gated});
  assign pf_rd_ordinary = port_read({5'h00, state_reg.pf_dir}, {5'h00, state_reg.pf_latch},
                                    {5'h00, pf_pad.in_gated});

  always_comb begin
    status_word = '0;
    status_word[gpef_pkg::GPEF_STAT_HIZ_BIT] = force_hiz;
    status_word[gpef_pkg::GPEF_STAT_EXTERNAL_RESET_ENABLE_BIT] = state_reg.external_reset_enable;
    status_word[gpef_pkg::GPEF_STAT_PE_LSB +: PE_W] = pe_level;
    status_word[gpef_pkg::GPEF_STAT_PF_LSB +: PF_W] = pf_level;
  end

  // Unused upper bits of each byte read as zero.
  always_comb begin
    rd_word = '0;
    if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_DATA)) begin
      rd_word[7:0] = pe_rd_ordinary;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_DIR)) begin
      rd_word[PE_W-1:0] = state_reg.pe_dir;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_PULLUP)) begin
      rd_word[PE_W-1:0] = state_reg.pe_pullup;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PF_DATA)) begin
      rd_word[7:0] = pf_rd_ordinary;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PF_DIR)) begin
      rd_word[PF_W-1:0] = state_reg.pf_dir;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_STANDBY)) begin
      rd_word[gpef_pkg::GPEF_SPL_BIT] = state_reg.standby_pin_state_bit;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_SYSCFG)) begin
      rd_word[gpef_pkg::GPEF_EXTERNAL_RESET_ENABLE_BIT] = state_reg.external_reset_enable;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_STATUS)) begin
      rd_word = status_word;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_RMW)) begin
      rd_word[PE_W-1:0] = state_reg.pe_latch;
    end else if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PF_RMW)) begin
      rd_word[PF_W-1:0] = state_reg.pf_latch;
    end else begin
      rd_word = '0;
    end
  end

  // ==========================================================================
  // Wishbone slave and register update
  // ==========================================================================

  // A request is served once: ack rises one cycle after strobe and drops the next cycle.
  assign bus_req = wb_cyc_i & wb_stb_i & ~state_reg.ack;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];

  always_comb begin
    state_next = state_reg;
    state_next.ack = bus_req;
    if (bus_req) begin
      state_next.rdata = wb_we_i ? '0 : rd_word;
    end
    if (bus_wr) begin
      // The latch always takes the write, whatever the direction; the pad only shows it on outputs.
      if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_DATA) ||
          reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_RMW)) begin
        state_next.pe_latch = wr_byte[PE_W-1:0];
      end
      if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_DIR)) begin
        state_next.pe_dir = wr_byte[PE_W-1:0];
      end
      if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PE_PULLUP)) begin
        state_next.pe_pullup = wr_byte[PE_W-1:0];
      end
      if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PF_DATA) ||
          reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PF_RMW)) begin
        state_next.pf_latch = wr_byte[PF_W-1:0];
      end
      if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_PF_DIR)) begin
        state_next.pf_dir = wr_byte[PF_W-1:0];
      end
      if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_STANDBY)) begin
        state_next.standby_pin_state_bit = wr_byte[gpef_pkg::GPEF_SPL_BIT];
      end
      if (reg_hit(wb_adr_i, gpef_pkg::GPEF_OFS_SYSCFG)) begin
        state_next.external_reset_enable = wr_byte[gpef_pkg::GPEF_EXTERNAL_RESET_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg.ack <= 1'b0;
      state_reg.rdata <= '0;
      state_reg.pe_latch <= gpef_pkg::GPEF_RST_PE_LATCH;
      state_reg.pe_dir <= gpef_pkg::GPEF_RST_PE_DIR;
      state_reg.pe_pullup <= gpef_pkg::GPEF_RST_PE_PULLUP;
      state_reg.pf_latch <= gpef_pkg::GPEF_RST_PF_LATCH;
      state_reg.pf_dir <= gpef_pkg::GPEF_RST_PF_DIR;
      state_reg.standby_pin_state_bit <= gpef_pkg::GPEF_RST_SPL;
      state_reg.external_reset_enable <= gpef_pkg::GPEF_RST_EXTERNAL_RESET_ENABLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.rdata;

endmodule

`default_nettype wire
